// ==== hdl/mux_parallel_host_port.sv ====
// Slave end of the multiplexed 8-bit parallel host port with its register bank.
`timescale 1ns/1ps
module mux_parallel_host_port
    import host_port_pkg::*;
#(
    parameter int REGS = REG_COUNT
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic host_port_select_n,
    input wire logic host_port_read_strobe_n,
    input wire logic host_port_write_strobe_n,
    input wire logic host_port_index_select,
    input wire logic [host_port_pkg::BYTE_W-1:0] host_port_byte_lines_in,
    output logic [host_port_pkg::BYTE_W-1:0] host_port_byte_lines_out,
    output logic host_port_byte_lines_oe_n,
    output logic [host_port_pkg::BYTE_W-1:0] reg_value [REGS],
    output logic [host_port_pkg::IDX_W-1:0] index_reg
);
    import host_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts once stages two and three agree.
    // The pins are asynchronous to ref_clk, so each control pin and the data byte
    // pass three flops; the first stage feeds only the second.
    logic [3+BYTE_W:0] pins_in;
    logic [3+BYTE_W:0] sync1_reg;
    logic [3+BYTE_W:0] sync2_reg;
    logic [3+BYTE_W:0] sync3_reg;
    logic [3+BYTE_W:0] clean_reg;

    assign pins_in = {host_port_select_n, host_port_read_strobe_n,
                      host_port_write_strobe_n, host_port_index_select,
                      host_port_byte_lines_in};

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            sync3_reg <= '1;
        end
        else
        begin
            sync1_reg <= pins_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Each bit takes a new value only when the last two stages agree.
    genvar b;
    generate
        for (b = 0; b <= 3 + BYTE_W; b++)
        begin : g_filter
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                    clean_reg[b] <= 1'b1;
                else if (sync2_reg[b] == sync3_reg[b])
                    clean_reg[b] <= sync3_reg[b];
            end
        end
    endgenerate

    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic idx_sel;
    logic [BYTE_W-1:0] wdata;
    assign sel_n = clean_reg[3+BYTE_W];
    assign rd_n = clean_reg[2+BYTE_W];
    assign wr_n = clean_reg[1+BYTE_W];
    assign idx_sel = clean_reg[BYTE_W];
    assign wdata = clean_reg[BYTE_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Cycle tracking: the access kind is fixed when select falls, since the read
    // strobe is held steady around that edge by the processor.
    port_state_t state_reg;
    logic sel_d_reg;
    logic wr_d_reg;
    logic sel_fall;
    logic wr_rise;
    assign sel_fall = sel_d_reg && !sel_n;
    assign wr_rise = !wr_d_reg && wr_n;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_d_reg <= 1'b1;
            wr_d_reg <= 1'b1;
        end
        else
        begin
            sel_d_reg <= sel_n;
            wr_d_reg <= wr_n;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= PORT_IDLE;
        else if (sel_n)
            state_reg <= PORT_IDLE;
        else if (sel_fall)
            state_reg <= rd_n ? PORT_WRITE : PORT_READ;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Writes commit on the rising edge of the write strobe, when data is settled.
    // A write strobe during a cycle classed as a read is ignored.
    logic write_commit;
    assign write_commit = wr_rise && !sel_n && state_reg == PORT_WRITE;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            index_reg <= INDEX_RESET;
        else if (write_commit && idx_sel == INDEX_SELECT_LEVEL)
            index_reg <= wdata;
    end

    // Register bank: one byte per entry, written only through the data register.
    genvar r;
    generate
        for (r = 0; r < REGS; r++)
        begin : g_bank
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                    reg_value[r] <= REG_RESET;
                else if (write_commit && idx_sel != INDEX_SELECT_LEVEL
                         && index_reg == IDX_W'(r))
                    reg_value[r] <= wdata;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read path: the byte is registered, and so is the enable, from the filtered pins, so the
    // bus floats some cycles after the processor lets go, once the synchronisers have seen it.
    logic [BYTE_W-1:0] read_byte;
    always_comb
    begin
        if (idx_sel == INDEX_SELECT_LEVEL)
            read_byte = index_reg;
        else if (32'(index_reg) < REGS)
            read_byte = reg_value[index_reg];
        else
            read_byte = REG_RESET;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            host_port_byte_lines_out <= REG_RESET;
        else
            host_port_byte_lines_out <= read_byte;
    end

    // Drive only in a selected read; low enable means the device drives.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            host_port_byte_lines_oe_n <= 1'b1;
        else
            host_port_byte_lines_oe_n <=
                !(state_reg == PORT_READ && !sel_n && !rd_n);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    chk_float_unselected: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ($past(sel_n) || $past(rd_n)) |-> host_port_byte_lines_oe_n)
        else $error("byte lines driven outside a selected read");
    chk_no_drive_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == PORT_WRITE) |=> host_port_byte_lines_oe_n)
        else $error("byte lines driven during a write cycle");
    chk_index_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (write_commit && idx_sel) |=> index_reg == $past(wdata))
        else $error("index register missed a write");
    chk_index_steady: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(write_commit && idx_sel) |=> $stable(index_reg))
        else $error("index register changed without an index write");
    chk_data_target: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (write_commit && !idx_sel && 32'(index_reg) < REGS)
        |=> reg_value[$past(index_reg)] == $past(wdata))
        else $error("data write missed the indexed register");
    chk_idle_deselect: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sel_n |=> state_reg == PORT_IDLE)
        else $error("cycle state held while deselected");
    chk_read_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == PORT_READ && idx_sel && $stable(index_reg))
        |=> host_port_byte_lines_out == $past(index_reg))
        else $error("index read returned a wrong byte");
    chk_write_classify: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sel_fall && rd_n) |=> state_reg == PORT_WRITE)
        else $error("write cycle not classified at select edge");
    chk_read_kind: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == PORT_READ) |-> !write_commit)
        else $error("write committed during a read cycle");
    cov_index_write: cover property (@(posedge ref_clk) write_commit && idx_sel);
    cov_data_write: cover property (@(posedge ref_clk) write_commit && !idx_sel);
    cov_data_read: cover property (@(posedge ref_clk) !host_port_byte_lines_oe_n && !idx_sel);
    cov_index_read: cover property (@(posedge ref_clk) !host_port_byte_lines_oe_n && idx_sel);
endmodule

// ==== hdl/host_port_pkg.sv ====
// Constants for the multiplexed 8-bit parallel host port.
package host_port_pkg;
    localparam int BYTE_W = 8;
    localparam int IDX_W = 8;
    localparam int REG_COUNT = 256;
    localparam logic [BYTE_W-1:0] REG_RESET = 8'h00;
    localparam logic [IDX_W-1:0] INDEX_RESET = 8'h00;
    localparam logic INDEX_SELECT_LEVEL = 1'b1;
    localparam int SYNC_STAGES = 3;
    typedef enum logic [1:0] {
        PORT_IDLE,
        PORT_READ,
        PORT_WRITE
    } port_state_t;
endpackage

// ==== tb/host_cpu_model.sv ====
// Behavioural model of the external processor that works the host port pins.
`timescale 1ns/1ps
module host_cpu_model
    import host_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [host_port_pkg::BYTE_W-1:0] dev_out,
    input wire logic dev_oe_n,
    output logic sel_n,
    output logic rd_n,
    output logic wr_n,
    output logic idx_sel,
    output logic [host_port_pkg::BYTE_W-1:0] pins
);
    logic [BYTE_W-1:0] drv = 8'h00;
    logic drv_en = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // Released lines show the inverse of the last byte, so stale data cannot pass as a read.
    assign pins = !dev_oe_n ? dev_out : (drv_en ? drv : ~drv);
    initial
    begin
        sel_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        idx_sel = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Every pin the model sets moves one nanosecond after a rising edge; byte lines driven by the device change on the edge itself.
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // One byte per write; the read strobe stays high for the whole cycle.
    task automatic put(input logic a, input logic [BYTE_W-1:0] d);
        step(1);
        rd_n = 1'b1;
        idx_sel = a;
        sel_n = 1'b0;
        step(2);
        drv = d;
        drv_en = 1'b1;
        wr_n = 1'b0;
        step(14);
        wr_n = 1'b1;
        step(8);
        drv_en = 1'b0;
        sel_n = 1'b1;
        step(8);
    endtask
    // Index select and read strobe settle two cycles before select falls.
    // Select stays low at least 70 ns; the byte is taken while the device drives it.
    task automatic get(input logic a, output logic [BYTE_W-1:0] d);
        step(1);
        idx_sel = a;
        rd_n = 1'b0;
        step(2);
        sel_n = 1'b0;
        for (int i = 0; i < 20 && dev_oe_n !== 1'b0; i++)
            step(1);
        step(8);
        d = pins;
        sel_n = 1'b1;
        step(1);
        rd_n = 1'b1;
        step(8);
    endtask
    // Strobes and data toggle while the port is not selected; the enable seen
    // while both strobes are low is handed back, since it must stay high.
    task automatic wiggle(output logic seen);
        step(1);
        idx_sel = 1'b1;
        drv = 8'h5a;
        drv_en = 1'b1;
        rd_n = 1'b0;
        wr_n = 1'b0;
        step(8);
        seen = dev_oe_n;
        wr_n = 1'b1;
        rd_n = 1'b1;
        step(8);
        drv_en = 1'b0;
    endtask
endmodule

// ==== tb/mux_parallel_host_port_test.sv ====
// Self-checking bench for the multiplexed host port.
`timescale 1ns/1ps
module mux_parallel_host_port_test;
    import host_port_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sel_n, rd_n, wr_n, idx_sel, oe_n, oe_seen;
    logic [BYTE_W-1:0] pins, dout, idx, dat, got;
    logic [BYTE_W-1:0] regs [REG_COUNT];
    logic [BYTE_W-1:0] shadow [REG_COUNT];
    logic [IDX_W-1:0] index_reg;
    logic [31:0] seed = 32'h415d;
    int fail_count = 0;
    int num_checks = 0;
    always #2.5 ref_clk = ~ref_clk;
    mux_parallel_host_port mux_parallel_host_port_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .host_port_select_n(sel_n), .host_port_read_strobe_n(rd_n),
        .host_port_write_strobe_n(wr_n), .host_port_index_select(idx_sel),
        .host_port_byte_lines_in(pins), .host_port_byte_lines_out(dout),
        .host_port_byte_lines_oe_n(oe_n), .reg_value(regs), .index_reg(index_reg));
    host_cpu_model cpu (.ref_clk(ref_clk), .dev_out(dout), .dev_oe_n(oe_n), .sel_n(sel_n),
        .rd_n(rd_n), .wr_n(wr_n), .idx_sel(idx_sel), .pins(pins));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        num_checks++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // The run needs about 3250 cycles; fifteen times that means a hang.
    initial
    begin
        #250000;
        fail_count++;
        conclude();
    end
    initial
    begin
        repeat (3) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge ref_clk);
        check("index_reg", INDEX_RESET, index_reg);
        check("oe_n", 8'h01, {7'h00, oe_n});
        for (int i = 0; i < REG_COUNT; i++)
        begin
            shadow[i] = REG_RESET;
            check("reg_value", REG_RESET, regs[i]);
        end
        $display("test reset done");
        // Both end indices first, then random ones; odd passes write data twice.
        for (int n = 0; n < 24; n++)
        begin
            seed = lfsr(seed);
            idx = (n == 0) ? 8'h00 : (n == 1) ? 8'hff : seed[7:0];
            seed = lfsr(seed);
            dat = seed[15:8];
            cpu.put(INDEX_SELECT_LEVEL, idx);
            check("index_reg", idx, index_reg);
            cpu.put(~INDEX_SELECT_LEVEL, dat);
            shadow[idx] = dat;
            if (n % 2 == 1)
            begin
                cpu.put(~INDEX_SELECT_LEVEL, ~dat);
                shadow[idx] = ~dat;
            end
            check("reg_value", shadow[idx], regs[idx]);
            check("index_reg kept", idx, index_reg);
            cpu.get(~INDEX_SELECT_LEVEL, got);
            check("read byte", shadow[idx], got);
            check("oe_n", 8'h01, {7'h00, oe_n});
            cpu.get(INDEX_SELECT_LEVEL, got);
            check("index read", idx, got);
        end
        $display("test random access done");
        cpu.wiggle(oe_seen);
        check("oe_n strobes unselected", 8'h01, {7'h00, oe_seen});
        check("index_reg unselected", idx, index_reg);
        check("reg_value unselected", shadow[idx], regs[idx]);
        check("oe_n unselected", 8'h01, {7'h00, oe_n});
        $display("test unselected strobes done");
        conclude();
    end
endmodule
